// ===== verilog/lpac_pkg.sv
package lpac_pkg;

  // Register bus geometry
  localparam int LPAC_ADDR_W = 8;
  localparam int LPAC_DATA_W = 32;
  localparam int LPAC_WORD_W = 16;

  // Printed index of the partner ability word; byte address is four times it
  localparam logic [LPAC_ADDR_W-1:0] LPAC_IDX_ABILITY = 8'h05;
  localparam logic [LPAC_ADDR_W-1:0] LPAC_ADDR_ABILITY = 8'h14;
  // Control and status registers added for this block
  localparam logic [LPAC_ADDR_W-1:0] LPAC_ADDR_CTRL = 8'h40;
  localparam logic [LPAC_ADDR_W-1:0] LPAC_ADDR_STAT = 8'h44;

  // Field positions of the ability word
  localparam int LPAC_BIT_MORE_PAGES = 15;
  localparam int LPAC_BIT_RECEIPT_CONFIRM = 14;
  localparam int LPAC_BIT_REMOTE_FAULT = 13;
  localparam int LPAC_BIT_MESSAGE_PAGE = 13;
  localparam int LPAC_BIT_RESERVED = 12;
  localparam int LPAC_BIT_ASYM_FLOW = 11;
  localparam int LPAC_BIT_SYM_PAUSE = 10;
  localparam int LPAC_BIT_FOUR_PAIR = 9;
  localparam int LPAC_BIT_FAST_FD = 8;
  localparam int LPAC_BIT_FAST_HD = 7;
  localparam int LPAC_BIT_TEN_FD = 6;
  localparam int LPAC_BIT_TEN_HD = 5;
  localparam int LPAC_SEL_MSB = 4;

  // Control and status bit positions
  localparam int LPAC_CTRL_NP_EN = 0;
  localparam int LPAC_STAT_VIEW_NEXT = 0;
  localparam int LPAC_STAT_NEXT_SEEN = 1;
  localparam int LPAC_STAT_DONE_SEEN = 2;

  // Reset values
  localparam logic [LPAC_WORD_W-1:0] LPAC_WORD_RST = 16'h0000;
  localparam logic LPAC_NP_EN_RST = 1'b1;

  // Bus responses
  localparam logic [1:0] LPAC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPAC_RESP_DECERR = 2'h3;

  // Negotiation phase that selects the view
  typedef enum logic [1:0] {
    LPAC_PH_BASE = 2'b01,
    LPAC_PH_NEXT = 2'b10
  } lpac_phase_e;

endpackage : lpac_pkg

// ===== verilog/lpac_axil_slave.sv
`timescale 1ns/1ps
module lpac_axil_slave
  import lpac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [LPAC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [LPAC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Read address and data
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [LPAC_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [LPAC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Register file side
  output logic wr_en,
  output logic [LPAC_ADDR_W-1:0] wr_addr,
  output logic [LPAC_DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [LPAC_ADDR_W-1:0] rd_addr,
  input wire logic [LPAC_DATA_W-1:0] rd_data,
  input wire logic rd_err
);

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [LPAC_ADDR_W-1:0] awaddr;
    logic [LPAC_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [LPAC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } lpac_slv_s;

  lpac_slv_s st_r;
  lpac_slv_s st_nxt;

  // Handshakes and register strobes
  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign wr_en = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign wr_addr = st_r.awaddr;
  assign wr_data = st_r.wdata;
  assign wr_strb = st_r.wstrb;
  assign rd_addr = s_axi_araddr;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // Next state of both channels
  always_comb begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_en) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_err ? LPAC_RESP_DECERR : LPAC_RESP_OKAY;
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_data;
      st_nxt.rresp = rd_err ? LPAC_RESP_DECERR : LPAC_RESP_OKAY;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : lpac_axil_slave

// ===== verilog/lpac_capture.sv
// Contract
// RL1: Ability word received from partner reads at offset 0x05, read-only, 16 bits.
// RL2: With next pages enabled, next-page word replaces base view after negotiation completes.
// RL3: Bit 15 shows partner requests next page; resets to 0.
// RL4: Bit 14 is partner acknowledge, taken from incoming pulse bursts.
// RL5: Software should not write bit 14 in the next-page view.
// RL6: Base view bit 13 shows partner remote fault; resets to 0.
// RL7: Bit 12 reserved: reads 0, software writes 0. Forced low in base view only; next-page view passes it as received.
// RL8: Bit 11 shows partner asymmetric pause support.
// RL9: Bit 10 shows partner symmetric pause support.
// RL10: Bit 9 shows partner four-pair capability.
// RL11: Bit 8 shows partner fast full-duplex capability.
// RL12: Bit 7 shows partner fast half-duplex capability.
// RL13: Bit 6 shows partner ten megabit full-duplex capability.
// RL14: Bit 5 shows partner ten megabit capability; resets to 0.
// RL15: Bits 4:0 hold partner selector code as received; reset to zero.
// RL16: Next-page view shares offset 0x05; negotiation phase picks the view.
// RL17: Next-page view bit 13 marks message page versus unformatted page.
// RL18: Reads have no side effects; writes to the ability word are ignored.
`timescale 1ns/1ps
module lpac_capture
  import lpac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [LPAC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [LPAC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Register bus read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [LPAC_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [LPAC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Negotiation engine side
  input wire logic lp_word_valid,
  input wire logic [LPAC_WORD_W-1:0] lp_word,
  input wire logic lp_word_is_next,
  input wire logic an_complete,
  input wire logic an_restart,
  // Visible state
  output logic [LPAC_WORD_W-1:0] partner_ability_word,
  output logic next_view_active
);

  typedef struct packed {
    logic [LPAC_WORD_W-1:0] base_r;
    logic [LPAC_WORD_W-1:0] next_r;
    logic [LPAC_WORD_W-1:0] view_r;
    logic next_seen;
    logic done_seen;
    logic np_en;
    lpac_phase_e phase;
  } lpac_cap_s;

  lpac_cap_s st_r;
  lpac_cap_s st_nxt;

  logic wr_en;
  logic [LPAC_ADDR_W-1:0] wr_addr;
  logic [LPAC_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [LPAC_ADDR_W-1:0] rd_addr;
  logic [LPAC_DATA_W-1:0] rd_data;
  logic rd_err;
  logic [LPAC_WORD_W-1:0] base_in;
  logic base_take;
  logic next_take;

  // Bus slave
  lpac_axil_slave i_lpac_axil_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Incoming page qualified; restart blocks capture
  assign base_take = lp_word_valid && !lp_word_is_next && !an_restart;
  assign next_take = lp_word_valid && lp_word_is_next && !an_restart;

  // Base page as stored; reserved bit forced low
  always_comb begin
    base_in = lp_word; // RL3 RL4 RL6 RL8 RL9 RL10 RL11 RL12 RL13 RL14 RL15
    base_in[LPAC_BIT_RESERVED] = 1'b0; // RL7
  end

  // Address decode: ability word read-only, writes dropped
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    unique case (rd_addr)
      LPAC_ADDR_ABILITY: rd_data[LPAC_WORD_W-1:0] = st_r.view_r; // RL1 RL16
      LPAC_ADDR_CTRL: rd_data[LPAC_CTRL_NP_EN] = st_r.np_en;
      LPAC_ADDR_STAT: begin
        rd_data[LPAC_STAT_VIEW_NEXT] = (st_r.phase == LPAC_PH_NEXT);
        rd_data[LPAC_STAT_NEXT_SEEN] = st_r.next_seen;
        rd_data[LPAC_STAT_DONE_SEEN] = st_r.done_seen;
      end
      default: rd_err = 1'b1;
    endcase
  end

  // Ability and status addresses accept writes without effect
  always_comb begin
    unique case (wr_addr)
      LPAC_ADDR_ABILITY, LPAC_ADDR_CTRL, LPAC_ADDR_STAT: wr_err = 1'b0; // RL18
      default: wr_err = 1'b1;
    endcase
  end

  // Capture, view selection and control
  always_comb begin
    st_nxt = st_r;
    if (wr_en && wr_addr == LPAC_ADDR_CTRL && wr_strb[0]) begin
      st_nxt.np_en = wr_data[LPAC_CTRL_NP_EN];
    end
    if (an_restart) begin
      st_nxt.base_r = LPAC_WORD_RST;
      st_nxt.next_r = LPAC_WORD_RST;
      st_nxt.next_seen = 1'b0;
      st_nxt.done_seen = 1'b0;
      st_nxt.phase = LPAC_PH_BASE;
    end else begin
      if (base_take) begin
        st_nxt.base_r = base_in; // RL4
      end
      if (next_take) begin
        st_nxt.next_r = lp_word; // RL17
        st_nxt.next_seen = 1'b1;
      end
      if (an_complete) begin
        st_nxt.done_seen = 1'b1;
      end
      unique case (st_r.phase)
        LPAC_PH_BASE: begin
          if (an_complete && st_r.np_en && st_r.next_seen) begin
            st_nxt.phase = LPAC_PH_NEXT; // RL2
          end
        end
        LPAC_PH_NEXT: st_nxt.phase = LPAC_PH_NEXT;
        default: st_nxt.phase = LPAC_PH_BASE;
      endcase
    end
    st_nxt.view_r = (st_nxt.phase == LPAC_PH_NEXT) ? st_nxt.next_r : st_nxt.base_r; // RL16
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.base_r <= LPAC_WORD_RST;
      st_r.next_r <= LPAC_WORD_RST;
      st_r.view_r <= LPAC_WORD_RST;
      st_r.next_seen <= 1'b0;
      st_r.done_seen <= 1'b0;
      st_r.np_en <= LPAC_NP_EN_RST;
      st_r.phase <= LPAC_PH_BASE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs from flops
  assign partner_ability_word = st_r.view_r;
  assign next_view_active = (st_r.phase == LPAC_PH_NEXT);

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ability_read_map: assert property ( // RL1
    rd_addr == LPAC_ADDR_ABILITY |-> rd_data == {16'h0000, partner_ability_word} && !rd_err)
    else $error("ability word read does not match current view");

  a_next_view_swap: assert property ( // RL2
    st_r.phase == LPAC_PH_BASE && an_complete && st_r.np_en && st_r.next_seen && !an_restart
    |=> next_view_active ##0 partner_ability_word == st_r.next_r)
    else $error("next page view not taken after completion");

  a_more_pages_bit: assert property ( // RL3
    base_take && st_r.phase == LPAC_PH_BASE && !(an_complete && st_r.np_en && st_r.next_seen)
    |=> partner_ability_word[LPAC_BIT_MORE_PAGES] == $past(lp_word[LPAC_BIT_MORE_PAGES]))
    else $error("more pages bit not captured");

  a_confirm_bit: assert property ( // RL4
    base_take |=> st_r.base_r[LPAC_BIT_RECEIPT_CONFIRM] == $past(lp_word[LPAC_BIT_RECEIPT_CONFIRM]))
    else $error("acknowledge bit not captured from burst");

  a_remote_fault_bit: assert property ( // RL6
    base_take |=> st_r.base_r[LPAC_BIT_REMOTE_FAULT] == $past(lp_word[LPAC_BIT_REMOTE_FAULT]))
    else $error("remote fault bit not captured");

  a_reserved_low: assert property ( // RL7
    st_r.base_r[LPAC_BIT_RESERVED] == 1'b0)
    else $error("reserved bit reads one");

  a_pause_bits: assert property ( // RL8 RL9
    base_take |=> st_r.base_r[LPAC_BIT_ASYM_FLOW:LPAC_BIT_SYM_PAUSE]
      == $past(lp_word[LPAC_BIT_ASYM_FLOW:LPAC_BIT_SYM_PAUSE]))
    else $error("pause bits not captured");

  a_tech_bits: assert property ( // RL10 RL11 RL12 RL13 RL14
    base_take |=> st_r.base_r[LPAC_BIT_FOUR_PAIR:LPAC_BIT_TEN_HD]
      == $past(lp_word[LPAC_BIT_FOUR_PAIR:LPAC_BIT_TEN_HD]))
    else $error("technology bits not captured");

  a_selector_field: assert property ( // RL15
    base_take |=> st_r.base_r[LPAC_SEL_MSB:0] == $past(lp_word[LPAC_SEL_MSB:0]))
    else $error("selector not captured as received");

  a_restart_clears: assert property ( // RL3 RL6 RL14 RL15
    an_restart |=> st_r.base_r == LPAC_WORD_RST && !next_view_active ##1 !next_view_active
      || st_r.base_r != LPAC_WORD_RST)
    else $error("restart does not clear captured word");

  a_next_view_word: assert property ( // RL16
    next_view_active && rd_addr == LPAC_ADDR_ABILITY |-> rd_data[15:0] == st_r.next_r)
    else $error("next view read returns wrong word");

  a_message_flag: assert property ( // RL17
    next_take |=> st_r.next_r[LPAC_BIT_MESSAGE_PAGE] == $past(lp_word[LPAC_BIT_MESSAGE_PAGE]))
    else $error("message page flag not captured");

  a_write_ignored: assert property ( // RL18
    wr_en && wr_addr == LPAC_ADDR_ABILITY && !lp_word_valid && !an_restart
    |=> st_r.base_r == $past(st_r.base_r) && st_r.next_r == $past(st_r.next_r))
    else $error("write changed the ability word");

  a_read_no_effect: assert property ( // RL18
    s_axi_arvalid && s_axi_arready && !lp_word_valid && !an_restart && !an_complete
    |=> $stable(partner_ability_word) && $stable(next_view_active))
    else $error("read changed captured state");

  a_read_data_reg: assert property ( // RL1
    s_axi_arvalid && s_axi_arready && s_axi_araddr == LPAC_ADDR_ABILITY
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(partner_ability_word)})
    else $error("registered read data differs from the ability word");

  a_read_resp_okay: assert property ( // RL1
    s_axi_arvalid && s_axi_arready && s_axi_araddr == LPAC_ADDR_ABILITY
    |=> s_axi_rresp == LPAC_RESP_OKAY)
    else $error("ability word read not answered with okay");

  a_write_resp_okay: assert property ( // RL18
    wr_en && wr_addr == LPAC_ADDR_ABILITY
    |=> s_axi_bvalid && s_axi_bresp == LPAC_RESP_OKAY)
    else $error("ignored write not answered with okay");

  a_next_view_holds: assert property ( // RL16
    next_view_active && !an_restart |=> next_view_active)
    else $error("next page view left without restart");

  a_swap_needs_enable: assert property ( // RL2
    !next_view_active && !st_r.np_en |=> !next_view_active)
    else $error("next page view taken while next pages disabled");

  a_next_word_whole: assert property ( // RL2
    next_take |=> st_r.next_r == $past(lp_word))
    else $error("next page word not captured whole");

  c_base_capture: cover property (base_take ##1 partner_ability_word != LPAC_WORD_RST);
  c_restart_with_page: cover property (an_restart && lp_word_valid);
  c_swap_to_next: cover property (!next_view_active ##1 next_view_active);
  c_read_next_view: cover property (next_view_active && s_axi_arvalid && s_axi_arready);
  c_write_ignored: cover property (wr_en && wr_addr == LPAC_ADDR_ABILITY);

endmodule : lpac_capture

// ===== test/lpac_link_model.sv
`timescale 1ns/1ps
module lpac_link_model
  import lpac_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Negotiation engine outputs
  output logic lp_word_valid,
  output logic [LPAC_WORD_W-1:0] lp_word,
  output logic lp_word_is_next,
  output logic an_complete,
  output logic an_restart
);
  // Idle state at time zero
  initial begin
    lp_word_valid = 1'b0;
    lp_word = 16'h0000;
    lp_word_is_next = 1'b0;
    an_complete = 1'b0;
    an_restart = 1'b0;
  end

  // One received page, then the word bus shows a changed pattern
  task automatic send_page(input logic [LPAC_WORD_W-1:0] w, input logic nxt);
    @(posedge aclk);
    lp_word_valid <= 1'b1;
    lp_word <= w;
    lp_word_is_next <= nxt;
    @(posedge aclk);
    lp_word_valid <= 1'b0;
    lp_word <= ~w;
    lp_word_is_next <= ~nxt;
  endtask : send_page

  // Successful end of negotiation, one cycle pulse
  task automatic finish_neg();
    @(posedge aclk);
    an_complete <= 1'b1;
    @(posedge aclk);
    an_complete <= 1'b0;
  endtask : finish_neg

  // Restart, optionally with a page offered at the same time
  task automatic restart_neg(input logic with_page, input logic [LPAC_WORD_W-1:0] w);
    @(posedge aclk);
    an_restart <= 1'b1;
    lp_word_valid <= with_page;
    lp_word <= w;
    @(posedge aclk);
    an_restart <= 1'b0;
    lp_word_valid <= 1'b0;
    lp_word <= ~w;
  endtask : restart_neg
endmodule : lpac_link_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb
  import lpac_pkg::*;
;
  logic aclk, aresetn;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic lp_word_valid, lp_word_is_next, an_complete, an_restart, next_view_active;
  logic [15:0] lp_word, partner_ability_word;
  int fails, total_checks;

  // Clock and watchdog; reset is driven by the main sequence
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test();
  end

  lpac_capture i_lpac_capture (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .lp_word_valid(lp_word_valid), .lp_word(lp_word), .lp_word_is_next(lp_word_is_next),
    .an_complete(an_complete), .an_restart(an_restart),
    .partner_ability_word(partner_ability_word), .next_view_active(next_view_active));

  lpac_link_model u_link (.aclk(aclk), .lp_word_valid(lp_word_valid), .lp_word(lp_word),
    .lp_word_is_next(lp_word_is_next), .an_complete(an_complete), .an_restart(an_restart));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // Write cycle: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  // Read cycle
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  // Read the ability word and compare data, response and port
  task automatic read_ability(input logic [15:0] exp);
    axi_read(LPAC_ADDR_ABILITY, rd, rsp);
    check(rd, {16'h0000, exp});
    check(rsp, LPAC_RESP_OKAY);
    check(partner_ability_word, exp);
  endtask : read_ability

  // Reset values of word, control and status
  task automatic t_reset();
    read_ability(16'h0000);
    axi_read(LPAC_ADDR_CTRL, rd, rsp);
    check(rd, 32'h00000001);
    axi_read(LPAC_ADDR_STAT, rd, rsp);
    check(rd, 32'h00000000);
    check(next_view_active, 1'b0);
  endtask : t_reset

  // Each base field alone, reserved bit forced to zero
  task automatic t_base_fields();
    logic [15:0] w;
    for (int i = 5; i < 16; i++) begin
      w = 16'h0001 << i;
      u_link.send_page(w, 1'b0);
      read_ability(w & 16'hEFFF);
    end
    u_link.send_page(16'h0015, 1'b0);
    read_ability(16'h0015);
    u_link.send_page(16'h001F, 1'b0);
    read_ability(16'h001F);
  endtask : t_base_fields

  // Writes ignored, reads without side effect, unmapped place refused
  task automatic t_write_ignored();
    u_link.send_page(16'h8421, 1'b0);
    axi_write(LPAC_ADDR_ABILITY, 32'h0000AFFF, rsp);
    check(rsp, LPAC_RESP_OKAY);
    read_ability(16'h8421);
    read_ability(16'h8421);
    axi_read(8'h80, rd, rsp);
    check(rd, 32'h00000000);
    check(rsp, LPAC_RESP_DECERR);
    axi_write(8'h80, 32'h00000000, rsp);
    check(rsp, LPAC_RESP_DECERR);
  endtask : t_write_ignored

  // Next page replaces base view only after completion
  task automatic t_next_view();
    u_link.send_page(16'h41E1, 1'b0);
    u_link.send_page(16'hB123, 1'b1);
    read_ability(16'h41E1);
    check(next_view_active, 1'b0);
    u_link.finish_neg();
    read_ability(16'hB123);
    check(next_view_active, 1'b1);
    axi_read(LPAC_ADDR_STAT, rd, rsp);
    check(rd, 32'h00000007);
  endtask : t_next_view

  // Restart clears; with next pages disabled the base view stays
  task automatic t_np_disabled();
    u_link.restart_neg(1'b0, 16'h0000);
    read_ability(16'h0000);
    check(next_view_active, 1'b0);
    axi_write(LPAC_ADDR_CTRL, 32'h00000000, rsp);
    u_link.send_page(16'h2ABC, 1'b1);
    u_link.finish_neg();
    read_ability(16'h0000);
    check(next_view_active, 1'b0);
    axi_read(LPAC_ADDR_STAT, rd, rsp);
    check(rd, 32'h00000006);
    axi_write(LPAC_ADDR_CTRL, 32'h00000001, rsp);
  endtask : t_np_disabled

  // A page offered during restart is not captured
  task automatic t_restart_blocks();
    u_link.restart_neg(1'b1, 16'h5A5A);
    read_ability(16'h0000);
    u_link.send_page(16'hC3E1, 1'b0);
    read_ability(16'hC3E1);
  endtask : t_restart_blocks

  // Main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_base_fields();
    t_write_ignored();
    t_next_view();
    t_np_disabled();
    t_restart_blocks();
    stop_test();
  end
endmodule : tb
